// ### src/ovs_pkg.sv
package ovs_pkg;
  // clock rate and timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int CNT_W = 18;
  localparam int unsigned HPER_NS = 12600;
  localparam int unsigned LPER_NS [4] = '{4130, 5960, 8020, 12600};

  // register indices; byte address is four times the index
  localparam logic [9:0] CTRL_IDX = 10'h030;
  localparam logic [9:0] STAT_IDX = 10'h031;
  localparam logic [9:0] CHAN_SEL_IDX = 10'h033;
  localparam logic [9:0] OVS_CFG_IDX = 10'h037;
  localparam logic [9:0] SETTLE_IDX = 10'h03e;

  // oversample config fields and reset
  localparam int ORDER_BIT = 7;
  localparam int HPER_LSB = 5;
  localparam int LPER_LSB = 3;
  localparam int CNT_LSB = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] MAX_OVS = 3'h5;

  // control register: period, aux settle code, extra channel enables
  localparam int PER_LSB = 0;
  localparam int AUXSET_LSB = 4;
  localparam int EXTRA_LSB = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0fff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // channel select layout
  localparam int CELL_SEL_LSB = 16;
  localparam int AUX_SEL_LSB = 8;
  localparam int DTEMP_BIT = 7;
  localparam int REF_BIT = 2;
  localparam logic [31:0] CHAN_SEL_MASK = 32'hffff_ff84;
  localparam int CELLSET_LSB = 4;
  localparam int STAT_CHAN_LSB = 1;
  localparam int STAT_DATA_LSB = 16;

  // channel numbering used by the sequencer
  localparam int N_CH = 30;
  localparam int LAST_CELL = 15;
  localparam int FIRST_AUX = 16;
  localparam int LAST_AUX = 23;
  localparam int CH_ATEMP = 24;
  localparam int CH_SUM = 27;
  localparam int CH_DTEMP = 28;
  localparam int CH_CORE = 29;
  localparam logic [4:0] CH_NONE = 5'h1f;

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c == 0) ? 1 : c;
  endfunction

  typedef struct packed {
    logic [4:0] chan;
    logic [15:0] data;
  } result_t;

  typedef enum {S_IDLE, S_WAIT, S_CONV} seq_state_t;
endpackage

// ### src/auto_monitor_oversampling_ctrl.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module auto_monitor_oversampling_ctrl import ovs_pkg::*; #(
  parameter int unsigned SETTLE_NS [16] = '{4130, 5960, 8020, 10000, 12600, 14900, 17400,
    19900, 24900, 30000, 40100, 60000, 100000, 200000, 500000, 1000000}
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic adc_sample_req,
  output logic [4:0] adc_sample_chan,
  input wire logic adc_sample_done,
  input wire logic [15:0] adc_sample_data,
  output logic result_valid,
  output result_t result
);

  logic [7:0] cfg_r;
  logic [31:0] ctrl_r;
  logic [31:0] chan_sel_r;
  logic [7:0] settle_r;
  seq_state_t state_r;
  logic [4:0] chan_r;
  logic [4:0] pass_r;
  logic [CNT_W-1:0] cnt_r;
  logic [20:0] acc_r [N_CH];

  // decoded fields
  logic order;
  logic [1:0] lper;
  logic [2:0] ovs;
  logic [3:0] period;
  logic [3:0] cell_set;
  logic [3:0] aux_set;
  logic [29:0] sel;
  logic [4:0] last_pass;
  assign order = cfg_r[ORDER_BIT];
  assign lper = cfg_r[LPER_LSB +: 2];
  // codes 6 and 7 are forbidden; treat them as 32 samples rather than overflow the sum
  assign ovs = (cfg_r[CNT_LSB +: 3] > MAX_OVS) ? MAX_OVS : cfg_r[CNT_LSB +: 3];
  assign last_pass = 5'((6'h1 << ovs) - 6'h1);
  assign period = ctrl_r[PER_LSB +: 4];
  assign cell_set = settle_r[CELLSET_LSB +: 4];
  assign aux_set = ctrl_r[AUXSET_LSB +: 4];
  assign sel = {ctrl_r[EXTRA_LSB + 3], chan_sel_r[DTEMP_BIT], ctrl_r[EXTRA_LSB + 2],
                ctrl_r[EXTRA_LSB + 1], chan_sel_r[REF_BIT], ctrl_r[EXTRA_LSB],
                chan_sel_r[AUX_SEL_LSB +: 8], chan_sel_r[CELL_SEL_LSB +: 16]};

  // address decode, shared by read and write paths
  function automatic logic [9:0] word_idx(input logic [11:0] a);
    return (a[1:0] == 2'h0) ? a[11:2] : 10'h3ff;
  endfunction

  // lowest selected channel in [lo..hi]
  function automatic logic [4:0] find_sel(input logic [29:0] s, input int lo, input int hi);
    logic [4:0] r;
    r = CH_NONE;
    for (int i = N_CH - 1; i >= 0; i--) begin
      if (i >= lo && i <= hi && s[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [CNT_W-1:0] settle_cyc(input logic [3:0] code);
    return CNT_W'(ns_to_cyc(SETTLE_NS[code]));
  endfunction

  function automatic logic [CNT_W-1:0] lper_cyc(input logic [1:0] code);
    return CNT_W'(ns_to_cyc(LPER_NS[code]));
  endfunction

  // the high period has a single legal code, so every code maps to 12.6 us
  function automatic logic [CNT_W-1:0] hper_cyc();
    return CNT_W'(ns_to_cyc(HPER_NS));
  endfunction

  function automatic logic is_rr(input logic [4:0] c, input logic ord);
    return ord && (c <= 5'(LAST_AUX));
  endfunction

  // wait before a sample, by channel group and position in its average
  function automatic logic [CNT_W-1:0] wait_cyc(input logic [4:0] c, input logic [4:0] p);
    logic first;
    first = is_rr(c, order) || (p == 5'h0);
    if (c <= 5'(LAST_CELL)) begin
      return first ? settle_cyc(cell_set) : hper_cyc();
    end else if (c <= 5'(LAST_AUX)) begin
      return first ? settle_cyc(aux_set) : lper_cyc(lper);
    end else if (c <= 5'(CH_SUM)) begin
      return hper_cyc();
    end
    return lper_cyc(lper);
  endfunction

  // convergent rounding of sum >> sh
  function automatic logic [15:0] conv_round(input logic [20:0] s, input logic [2:0] sh);
    logic [20:0] q;
    logic [20:0] rem;
    logic [20:0] half;
    q = s >> sh;
    rem = s & ((21'h1 << sh) - 21'h1);
    half = (sh == 3'h0) ? 21'h0 : (21'h1 << (sh - 3'h1));
    if (sh != 3'h0 && (rem > half || (rem == half && q[0]))) begin
      q = q + 21'h1;
    end
    return q[15:0];
  endfunction

  // next channel and pass after a finished sample
  logic [4:0] grp_next;
  logic [4:0] first_chan;
  logic [4:0] next_chan;
  logic [4:0] next_pass;
  logic pass_done;
  int grp_lo;
  int grp_hi;
  assign pass_done = (pass_r >= last_pass);
  assign first_chan = find_sel(sel, 0, N_CH - 1);
  always_comb begin
    grp_lo = (chan_r <= 5'(LAST_CELL)) ? 0 : FIRST_AUX;
    grp_hi = (chan_r <= 5'(LAST_CELL)) ? LAST_CELL : LAST_AUX;
    grp_next = find_sel(sel, int'(chan_r) + 1, grp_hi);
    next_chan = chan_r;
    next_pass = pass_r + 5'h1;
    if (!is_rr(chan_r, order)) begin
      if (pass_done) begin
        next_chan = find_sel(sel, int'(chan_r) + 1, N_CH - 1);
        next_pass = 5'h0;
      end
    end else if (grp_next != CH_NONE) begin
      next_chan = grp_next;
      next_pass = pass_r;
    end else if (!pass_done) begin
      next_chan = find_sel(sel, grp_lo, grp_hi);
    end else begin // group done before the next group starts
      next_chan = find_sel(sel, grp_hi + 1, N_CH - 1);
      next_pass = 5'h0;
    end
  end

  logic [20:0] acc_nxt;
  assign acc_nxt = ((pass_r == 5'h0) ? 21'h0 : acc_r[chan_r]) + {5'h0, adc_sample_data};

  // APB slave: zero wait, answer registered in the setup cycle
  logic wr_en;
  logic [9:0] widx;
  assign wr_en = psel && penable && pready && pwrite;
  assign widx = word_idx(paddr);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (widx)
          OVS_CFG_IDX: prdata <= {24'h0, cfg_r};
          CTRL_IDX: prdata <= ctrl_r;
          CHAN_SEL_IDX: prdata <= chan_sel_r;
          SETTLE_IDX: prdata <= {24'h0, settle_r};
          STAT_IDX: prdata <= {result.data, 10'h000, chan_r, state_r != S_IDLE};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // writable registers; status is read-only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
      ctrl_r <= CTRL_RESET;
      chan_sel_r <= 32'h0000_0000;
      settle_r <= 8'h00;
    end else if (wr_en) begin
      case (widx)
        OVS_CFG_IDX: cfg_r <= pwdata[7:0];
        CTRL_IDX: ctrl_r <= pwdata & CTRL_MASK;
        CHAN_SEL_IDX: chan_sel_r <= pwdata & CHAN_SEL_MASK;
        SETTLE_IDX: settle_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // sequencer: wait, request a conversion, fold the result in, pick next
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      chan_r <= 5'h0;
      pass_r <= 5'h0;
      cnt_r <= '0;
      adc_sample_req <= 1'b0;
    end else begin
      adc_sample_req <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (period != 4'h0 && first_chan != CH_NONE) begin
            chan_r <= first_chan;
            pass_r <= 5'h0;
            cnt_r <= wait_cyc(first_chan, 5'h0) - 1'b1;
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (period == 4'h0) begin
            state_r <= S_IDLE;
          end else if (cnt_r == '0) begin
            adc_sample_req <= 1'b1;
            state_r <= S_CONV;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        S_CONV: begin
          // a conversion in flight is always finished, even if monitoring stops
          if (adc_sample_done) begin
            if (period == 4'h0) begin
              state_r <= S_IDLE;
            end else if (next_chan != CH_NONE) begin
              chan_r <= next_chan;
              pass_r <= next_pass;
              cnt_r <= wait_cyc(next_chan, next_pass) - 1'b1;
              state_r <= S_WAIT;
            end else begin
              state_r <= S_IDLE; // scan over; restart from the first channel
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // running sums, one per channel so round-robin passes can interleave
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N_CH; i++) begin
        acc_r[i] <= 21'h0;
      end
    end else if (state_r == S_CONV && adc_sample_done) begin
      acc_r[chan_r] <= acc_nxt;
    end
  end

  // result out after the last sample of an average
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid <= 1'b0;
      result <= '0;
    end else begin
      result_valid <= 1'b0;
      if (state_r == S_CONV && adc_sample_done && pass_done) begin
        result_valid <= 1'b1;
        result.chan <= chan_r;
        result.data <= conv_round(acc_nxt, ovs);
      end
    end
  end

  assign adc_sample_chan = chan_r;

  sequence s_done;
    state_r == S_CONV && adc_sample_done && period != 4'h0;
  endsequence

  sequence s_wait_entry;
    state_r == S_WAIT && $past(state_r) != S_WAIT;
  endsequence

  chk_cfg_store: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && widx == OVS_CFG_IDX |=> cfg_r == $past(pwdata[7:0]))
    else $error("config byte not stored");
  chk_idle_off: assert property (@(posedge clk) disable iff (!rst_n)
    period == 4'h0 && state_r != S_CONV |=> state_r == S_IDLE && !adc_sample_req)
    else $error("sampling while monitor period is zero");
  chk_repeat_same: assert property (@(posedge clk) disable iff (!rst_n)
    s_done ##0 (!is_rr(chan_r, order) && !pass_done)
    |=> state_r == S_WAIT && chan_r == $past(chan_r) && pass_r == $past(pass_r) + 5'h1)
    else $error("repeat ordering left channel early");
  chk_rr_moves: assert property (@(posedge clk) disable iff (!rst_n)
    s_done ##0 (is_rr(chan_r, order) && grp_next != CH_NONE)
    |=> chan_r == $past(grp_next) && pass_r == $past(pass_r))
    else $error("round robin did not advance within group");
  chk_extra_stay: assert property (@(posedge clk) disable iff (!rst_n)
    s_done ##0 (chan_r >= 5'(CH_ATEMP) && !pass_done) |=> chan_r == $past(chan_r))
    else $error("extra channel was reordered");
  chk_cell_settle: assert property (@(posedge clk) disable iff (!rst_n)
    s_wait_entry ##0 ($past(order) && chan_r <= 5'(LAST_CELL))
    |-> cnt_r == settle_cyc($past(cell_set)) - 1'b1)
    else $error("cell settle wait wrong");
  // the wait counter itself bounds the settle time: it counts down and fires at zero
  chk_wait_count: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == S_WAIT && cnt_r != '0 && period != 4'h0
    |=> state_r == S_WAIT && cnt_r == $past(cnt_r) - 1'b1)
    else $error("settle counter did not count down");
  chk_wait_fire: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == S_WAIT && cnt_r == '0 && period != 4'h0
    |=> state_r == S_CONV && adc_sample_req)
    else $error("settle wait did not end in a request");
  chk_high_period: assert property (@(posedge clk) disable iff (!rst_n)
    s_wait_entry ##0 (chan_r >= 5'(CH_ATEMP) && chan_r <= 5'(CH_SUM))
    |-> cnt_r == hper_cyc() - 1'b1)
    else $error("high group period wrong");
  chk_low_period: assert property (@(posedge clk) disable iff (!rst_n)
    s_wait_entry ##0 (chan_r >= 5'(CH_DTEMP) && chan_r <= 5'(CH_CORE))
    |-> cnt_r == lper_cyc($past(lper)) - 1'b1)
    else $error("low group period wrong");
  chk_single_pass: assert property (@(posedge clk) disable iff (!rst_n)
    s_done ##0 (ovs == 3'h0) |=> result_valid && result.data == $past(adc_sample_data))
    else $error("single sample not passed through");
  chk_result_count: assert property (@(posedge clk) disable iff (!rst_n)
    result_valid |-> $past(pass_r) >= $past(last_pass))
    else $error("result before all samples taken");

endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ovs_pkg::*;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic adc_sample_req;
  logic [4:0] adc_sample_chan;
  logic adc_sample_done = 1'b0;
  logic [15:0] adc_sample_data = 16'h0000;
  logic result_valid;
  result_t result;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int dly = 0;
  int req_cyc[$];
  int done_cyc[$];
  logic [4:0] req_ch[$];
  logic [15:0] smp_q[$];
  result_t res_q[$];
  logic [31:0] rd;
  logic err;
  logic [15:0] exp_b[4] = '{16'h0004, 16'h0002, 16'hfffe, 16'h0002};
  int low_cyc[4] = '{826, 1192, 1604, 2520};
  logic [11:0] cfg_a;

  // short settle table keeps each settle wait to 4 cycles
  auto_monitor_oversampling_ctrl #(.SETTLE_NS('{default: 20})) i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_sample_req(adc_sample_req),
    .adc_sample_chan(adc_sample_chan), .adc_sample_done(adc_sample_done),
    .adc_sample_data(adc_sample_data), .result_valid(result_valid), .result(result));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // converter stand-in: answers each request three cycles later, logs traffic
  always @(posedge clk) begin
    cyc <= cyc + 1;
    adc_sample_done <= 1'b0;
    if (adc_sample_req === 1'b1) begin
      req_cyc.push_back(cyc);
      req_ch.push_back(adc_sample_chan);
      dly <= 3;
    end else if (dly > 0) begin
      dly <= dly - 1;
    end
    if (dly == 1) begin
      adc_sample_done <= 1'b1;
      adc_sample_data <= (smp_q.size() > 0) ? smp_q.pop_front() : 16'h0000;
      done_cyc.push_back(cyc);
    end
    if (result_valid === 1'b1) res_q.push_back(result);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // gap from a converter answer to the next request, in cycles
  task automatic gap(input int i, input int w);
    int g;
    g = req_cyc[i] - done_cyc[i-1];
    check({31'h0, (g >= w + 1) && (g <= w + 5)}, 32'h1);
  endtask

  // configure, scan until n results arrive, stop and confirm silence
  task automatic run(input logic [7:0] cfg, input logic [31:0] sel, input int n);
    int i;
    req_cyc.delete();
    req_ch.delete();
    done_cyc.delete();
    res_q.delete();
    apb(1'b1, cfg_a, {24'h0, cfg});
    apb(1'b1, {CHAN_SEL_IDX, 2'b00}, sel);
    apb(1'b1, {CTRL_IDX, 2'b00}, 32'h0000_0001);
    for (i = 0; i < 30000 && res_q.size() < n; i++) @(posedge clk);
    if (res_q.size() < n) begin
      n_fail++;
      print_verdict();
    end
    apb(1'b1, {CTRL_IDX, 2'b00}, 32'h0000_0000);
    repeat (20) @(posedge clk);
    i = req_cyc.size();
    repeat (3000) @(posedge clk);
    check(req_cyc.size(), i);
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cfg_a = {OVS_CFG_IDX, 2'b00};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // reset value, all eight bits stored, unmapped place refused
    apb(1'b0, cfg_a, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, cfg_a, 32'h0000_00ff);
    apb(1'b0, cfg_a, 32'h0);
    check(rd, 32'h0000_00ff);
    apb(1'b1, cfg_a, 32'h0000_00a5);
    apb(1'b0, cfg_a, 32'h0);
    check(rd, 32'h0000_00a5);
    apb(1'b0, 12'h0fc, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test registers done");
    // repeat order, pairs on one cell, rounding ties to even
    smp_q = '{16'h0003, 16'h0004, 16'h0002, 16'h0003,
      16'hffff, 16'hfffe, 16'h0001, 16'h0002};
    run(8'h79, 32'h0001_0000, 4);
    for (int i = 0; i < 4; i++) check(res_q[i], {5'h00, exp_b[i]});
    gap(1, 2520);
    gap(2, 4);
    gap(3, 2520);
    // the restarted scan never reaches its second sample, so the last average stays
    apb(1'b0, {STAT_IDX, 2'b00}, 32'h0);
    check(rd, {exp_b[3], 16'h0000});
    $display("test repeat order done");
    // round robin over two cells, settle before every sample
    smp_q = '{16'h000a, 16'h0014, 16'h001e, 16'h0028};
    run(8'hf9, 32'h0003_0000, 2);
    for (int i = 0; i < 4; i++) check(req_ch[i], i % 2);
    for (int i = 1; i < 4; i++) gap(i, 4);
    check(res_q[0], {5'h00, 16'h0014});
    check(res_q[1], {5'h01, 16'h001e});
    $display("test round robin done");
    // each low-group period code on an aux channel in repeat order
    for (int c = 0; c < 4; c++) begin
      smp_q = '{16'h0100, 16'h0101};
      run({1'b0, 2'b11, c[1:0], 3'b001}, 32'h0000_0100, 1);
      gap(1, low_cyc[c]);
      check(res_q[0], {5'h10, 16'h0100});
    end
    $display("test low period done");
    // count zero stores a single sample untouched
    smp_q = '{16'h1234};
    run(8'h78, 32'h0001_0000, 1);
    check(res_q[0], {5'h00, 16'h1234});
    $display("test single sample done");
    print_verdict();
  end
endmodule
